//--- pli_pkg.sv
// Shared constants for the fabric interrupt generator
package pli_pkg;

  // System placement of the register block and its single register
  localparam logic [31:0] PLI_SYS_BASE    = 32'h7860_0000;
  localparam logic [31:0] PLI_CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] PLI_CTRL_RESET  = 32'h0000_0000;
  localparam int          PLI_PEND_BIT    = 0;
  localparam logic        PLI_IRQ_IDLE_N  = 1'b1;

  // Bus shape
  localparam int PLI_DATA_W = 32;
  localparam int PLI_STRB_W = 4;
  localparam int PLI_ADDR_W = 16;

  // Response codes of the register bus
  localparam logic [1:0] PLI_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PLI_RESP_SLVERR = 2'b10;

  // Write channel states
  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_ACK  = 3'b010,
    WS_RESP = 3'b100
  } pli_wr_state_e;

  // Read channel states
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_ACK  = 3'b010,
    RS_DATA = 3'b100
  } pli_rd_state_e;

endpackage : pli_pkg

//--- pli_irq_flag.sv
`timescale 1ns/10ps

module pli_irq_flag
  import pli_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Set and write requests
  input  wire logic interruptTick,
  input  wire logic wrEn,
  input  wire logic wrBit,
  // Flag and active-low line
  output logic      pendingFlag,
  output logic      secondCpuIrqLineN
);

  logic pending_ff;
  logic nxt_pending;
  logic irqN_ff;
  logic nxt_irqN;

  // Tick wins over a clearing write so no request is lost
  always_comb begin
    nxt_pending = pending_ff;
    if (wrEn) begin
      nxt_pending = wrBit;
    end
    if (interruptTick) begin
      nxt_pending = 1'b1;
    end
    nxt_irqN = ~nxt_pending;
  end

  // Line flop tracks the flag flop edge for edge, no extra lag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_ff <= PLI_CTRL_RESET[PLI_PEND_BIT];
      irqN_ff    <= PLI_IRQ_IDLE_N;
    end else begin
      pending_ff <= nxt_pending;
      irqN_ff    <= nxt_irqN;
    end
  end

  assign pendingFlag       = pending_ff;
  assign secondCpuIrqLineN = irqN_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_tick_sets: assert property (interruptTick |=> pending_ff)
    else $error("tick did not set pending flag");
  a_write_sets: assert property (wrEn && wrBit |=> pending_ff)
    else $error("write of one did not set pending flag");
  a_clear_by_write: assert property ($fell(pending_ff) |-> $past(wrEn && !wrBit))
    else $error("pending flag cleared without a write of zero");
  a_set_wins: assert property (interruptTick && wrEn && !wrBit |=> pending_ff)
    else $error("clearing write beat a tick");
  a_line_low: assert property (irqN_ff == !pending_ff)
    else $error("interrupt line level disagrees with flag");

endmodule : pli_irq_flag

//--- pli_irq_gen.sv
`timescale 1ns/10ps
// Notes on behaviour
// - One 32-bit control register at offset zero
// - Upper bits store and read back written value
// - Bit zero reflects interrupt asserted state
// - Tick input sets bit zero
// - Processor writing one sets bit zero
// - Only a processor write of zero clears
// - Set bit zero drives the interrupt line
// - Register reached over bus slave port

module pli_irq_gen
  import pli_pkg::*;
#(
  parameter int ADDR_W = PLI_ADDR_W
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // Event source, one-cycle pulse
  input  wire logic                  interruptTick,
  // Interrupt toward the second core
  output logic                       secondCpuIrqLineN,
  // Write address channel
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // Write data channel
  input  wire logic [PLI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [PLI_STRB_W-1:0] s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // Write response channel
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // Read data channel
  output logic [PLI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // Write channel state
  pli_wr_state_e             wrState_ff;
  pli_wr_state_e             nxt_wrState;
  logic                      awReady_ff;
  logic                      nxt_awReady;
  logic                      bValid_ff;
  logic                      nxt_bValid;
  logic [1:0]                bResp_ff;
  logic [1:0]                nxt_bResp;
  // Read channel state
  pli_rd_state_e             rdState_ff;
  pli_rd_state_e             nxt_rdState;
  logic                      arReady_ff;
  logic                      nxt_arReady;
  logic                      rValid_ff;
  logic                      nxt_rValid;
  logic [1:0]                rResp_ff;
  logic [1:0]                nxt_rResp;
  logic [PLI_DATA_W-1:0]     rData_ff;
  logic [PLI_DATA_W-1:0]     nxt_rData;
  // Spare control bits and decode
  logic [PLI_DATA_W-1:1]     spare_ff;
  logic [PLI_DATA_W-1:1]     nxt_spare;
  logic [PLI_DATA_W-1:0]     laneMask;
  logic                      wrFire;
  logic                      wrHit;
  logic                      rdFire;
  logic                      rdHit;
  logic                      pendWrEn;
  logic                      pendingFlag;
  logic [PLI_DATA_W-1:0]     ctrlValue;

  // Only one word exists, so every other word is answered with an error
  assign wrHit = (s_axi_awaddr[ADDR_W-1:2] == PLI_CTRL_OFFSET[ADDR_W-1:2]);
  assign rdHit = (s_axi_araddr[ADDR_W-1:2] == PLI_CTRL_OFFSET[ADDR_W-1:2]);

  // Write takes effect in the cycle the ready flops are high
  assign wrFire = (wrState_ff == WS_ACK);
  assign rdFire = (rdState_ff == RS_ACK);

  // Byte lanes expand into a bit mask
  for (genvar lane = 0; lane < PLI_STRB_W; lane++) begin : g_lane
    assign laneMask[8*lane +: 8] = {8{s_axi_wstrb[lane]}};
  end

  // A write only moves the pending bit when its own lane is enabled
  assign pendWrEn  = wrFire && wrHit && s_axi_wstrb[0];
  assign ctrlValue = {spare_ff, pendingFlag};

  // Write channel: address and data are taken together
  always_comb begin
    nxt_wrState = wrState_ff;
    nxt_bResp   = bResp_ff;
    case (wrState_ff)
      WS_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          nxt_wrState = WS_ACK;
        end
      end
      WS_ACK: begin
        nxt_wrState = WS_RESP;
        nxt_bResp   = wrHit ? PLI_RESP_OKAY : PLI_RESP_SLVERR;
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          nxt_wrState = WS_IDLE;
        end
      end
      default: begin
        nxt_wrState = WS_IDLE;
      end
    endcase
    nxt_awReady = (nxt_wrState == WS_ACK);
    nxt_bValid  = (nxt_wrState == WS_RESP);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrState_ff <= WS_IDLE;
      awReady_ff <= 1'b0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= PLI_RESP_OKAY;
    end else begin
      wrState_ff <= nxt_wrState;
      awReady_ff <= nxt_awReady;
      bValid_ff  <= nxt_bValid;
      bResp_ff   <= nxt_bResp;
    end
  end

  // Read channel: data is captured while the address is held
  always_comb begin
    nxt_rdState = rdState_ff;
    nxt_rResp   = rResp_ff;
    nxt_rData   = rData_ff;
    case (rdState_ff)
      RS_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_rdState = RS_ACK;
        end
      end
      RS_ACK: begin
        nxt_rdState = RS_DATA;
        nxt_rResp   = rdHit ? PLI_RESP_OKAY : PLI_RESP_SLVERR;
        nxt_rData   = rdHit ? ctrlValue : '0;
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          nxt_rdState = RS_IDLE;
        end
      end
      default: begin
        nxt_rdState = RS_IDLE;
      end
    endcase
    nxt_arReady = (nxt_rdState == RS_ACK);
    nxt_rValid  = (nxt_rdState == RS_DATA);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdState_ff <= RS_IDLE;
      arReady_ff <= 1'b0;
      rValid_ff  <= 1'b0;
      rResp_ff   <= PLI_RESP_OKAY;
      rData_ff   <= '0;
    end else begin
      rdState_ff <= nxt_rdState;
      arReady_ff <= nxt_arReady;
      rValid_ff  <= nxt_rValid;
      rResp_ff   <= nxt_rResp;
      rData_ff   <= nxt_rData;
    end
  end

  // Spare bits have no function but software may park values there
  always_comb begin
    nxt_spare = spare_ff;
    if (wrFire && wrHit) begin
      nxt_spare = (spare_ff & ~laneMask[PLI_DATA_W-1:1])
                | (s_axi_wdata[PLI_DATA_W-1:1] & laneMask[PLI_DATA_W-1:1]);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spare_ff <= PLI_CTRL_RESET[PLI_DATA_W-1:1];
    end else begin
      spare_ff <= nxt_spare;
    end
  end

  // Pending flag and its line live in one flop pair
  pli_irq_flag u_flag (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .interruptTick     (interruptTick),
    .wrEn              (pendWrEn),
    .wrBit             (s_axi_wdata[PLI_PEND_BIT]),
    .pendingFlag       (pendingFlag),
    .secondCpuIrqLineN (secondCpuIrqLineN)
  );

  // Bus outputs straight from their flops
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = awReady_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rresp   = rResp_ff;
  assign s_axi_rdata   = rData_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_wrAsked;
    wrState_ff == WS_IDLE && s_axi_awvalid && s_axi_wvalid;
  endsequence

  a_wr_resp_time: assert property (s_wrAsked |=> s_wrTaken ##1 s_axi_bvalid)
    else $error("write not answered two cycles after request");

  a_unmapped_err: assert property (s_wrTaken and !wrHit |=> s_axi_bresp == PLI_RESP_SLVERR)
    else $error("unmapped write not answered with error");

  a_spare_store: assert property (s_wrTaken and wrHit and s_axi_wstrb == 4'hF
                                  |=> spare_ff == $past(s_axi_wdata[PLI_DATA_W-1:1]))
    else $error("spare bits did not store written value");

  a_read_back: assert property (s_rdTaken and rdHit
                                |=> s_axi_rvalid && s_axi_rresp == PLI_RESP_OKAY
                                    && s_axi_rdata == $past(ctrlValue))
    else $error("read data does not match control register");

  a_line_follows: assert property (secondCpuIrqLineN == !pendingFlag)
    else $error("interrupt line not driven from pending bit");

  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before acceptance");

endmodule : pli_irq_gen

//--- pli_cpu_model.sv
`timescale 1ns/10ps

module pli_cpu_model
  import pli_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Tick source
  output logic             interruptTick,
  // Write side
  output logic [15:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read side
  output logic [15:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {interruptTick, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0000_0000_0000_0000;
  end

  // One write; released address and data show the inverse so stale values never pass, strobes keep their value
  task automatic write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       input int stall, output logic [1:0] resp);
    int n;
    n = 0;
    @(negedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {a, d, s};
    {s_axi_awvalid, s_axi_wvalid} = 2'b11;
    do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready) && ++n < 50);
    @(negedge core_clk);
    {s_axi_awvalid, s_axi_wvalid} = 2'b00;
    {s_axi_awaddr, s_axi_wdata} = ~{a, d};
    // Slow answer: hold off the response
    repeat (stall) @(negedge core_clk);
    s_axi_bready = 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid && ++n < 100);
    resp = s_axi_bvalid ? s_axi_bresp : 2'bxx; // Limit ran out: forces a mismatch
    @(negedge core_clk);
    s_axi_bready = 1'b0;
  endtask : write

  // One read
  task automatic read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(negedge core_clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do @(posedge core_clk); while (!s_axi_arready && ++n < 50);
    @(negedge core_clk);
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
    s_axi_rready = 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid && ++n < 100);
    {d, resp} = s_axi_rvalid ? {s_axi_rdata, s_axi_rresp} : {34{1'bx}}; // Limit ran out
    @(negedge core_clk);
    s_axi_rready = 1'b0;
  endtask : read

  // One-cycle tick, optionally aligned to a write being accepted
  task automatic tick(input bit onAccept);
    int n;
    n = 0;
    @(negedge core_clk);
    while (onAccept && !s_axi_awready && ++n < 50) @(negedge core_clk);
    interruptTick = 1'b1;
    @(negedge core_clk);
    interruptTick = 1'b0;
  endtask : tick
endmodule : pli_cpu_model

//--- pli_irq_gen_tb_top.sv
`timescale 1ns/10ps

module pli_irq_gen_tb_top;
  import pli_pkg::*;
  // Clock, reset and wiring
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        interruptTick, secondCpuIrqLineN;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errors = 0;
  int          compares = 0;

  always #25 core_clk = ~core_clk;

  pli_irq_gen i_dut (.core_clk, .arst_n, .interruptTick, .secondCpuIrqLineN,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  pli_cpu_model i_cpu (.core_clk, .interruptTick, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input int stall, input logic [1:0] expResp);
    logic [1:0] r;
    i_cpu.write(a, d, s, stall, r);
    chk({30'h0, r}, {30'h0, expResp}, "write response");
  endtask : wr

  task automatic rdchk(input logic [15:0] a, input logic [31:0] expData,
                       input logic [1:0] expResp);
    logic [31:0] d;
    logic [1:0]  r;
    i_cpu.read(a, d, r);
    chk(d, expData, "read data");
    chk({30'h0, r}, {30'h0, expResp}, "read response");
  endtask : rdchk

  task automatic irqchk(input logic expN);
    @(negedge core_clk);
    chk({31'h0, secondCpuIrqLineN}, {31'h0, expN}, "interrupt line");
  endtask : irqchk

  // Reset values and idle line
  task automatic test_reset;
    rdchk(PLI_CTRL_OFFSET[15:0], PLI_CTRL_RESET, PLI_RESP_OKAY);
    irqchk(PLI_IRQ_IDLE_N);
  endtask : test_reset

  // Upper bits store; lane 0 off leaves the flag alone, slow response
  task automatic test_upper;
    wr(16'h0000, 32'hA5A5_A5A4, 4'hF, 0, PLI_RESP_OKAY);
    rdchk(16'h0000, 32'hA5A5_A5A4, PLI_RESP_OKAY);
    wr(16'h0000, 32'hFFFF_FFFF, 4'hE, 3, PLI_RESP_OKAY);
    rdchk(16'h0000, 32'hFFFF_FFA4, PLI_RESP_OKAY);
    irqchk(1'b1);
  endtask : test_upper

  // Tick sets and stays until written back to zero
  task automatic test_tick;
    i_cpu.tick(1'b0);
    irqchk(1'b0);
    repeat (5) @(negedge core_clk);
    irqchk(1'b0);
    rdchk(16'h0000, 32'hFFFF_FFA5, PLI_RESP_OKAY);
    wr(16'h0000, 32'h1234_5670, 4'hF, 0, PLI_RESP_OKAY);
    irqchk(1'b1);
  endtask : test_tick

  // Software set through byte lane 0 only
  task automatic test_swset;
    wr(16'h0000, 32'h0000_0001, 4'h1, 0, PLI_RESP_OKAY);
    irqchk(1'b0);
    rdchk(16'h0000, 32'h1234_5601, PLI_RESP_OKAY);
  endtask : test_swset

  // Clearing write and tick land on the same edge
  task automatic test_race;
    fork
      wr(16'h0000, 32'h0000_0000, 4'hF, 0, PLI_RESP_OKAY);
      i_cpu.tick(1'b1);
    join
    irqchk(1'b0);
    rdchk(16'h0000, 32'h0000_0001, PLI_RESP_OKAY);
    wr(16'h0000, 32'h0000_0000, 4'hF, 0, PLI_RESP_OKAY);
    irqchk(1'b1);
  endtask : test_race

  // Unmapped place refused, register untouched
  task automatic test_unmapped;
    wr(16'h0010, 32'h0000_0001, 4'hF, 0, PLI_RESP_SLVERR);
    irqchk(1'b1);
    rdchk(16'h0010, 32'h0000_0000, PLI_RESP_SLVERR);
    rdchk(16'h0000, 32'h0000_0000, PLI_RESP_OKAY);
  endtask : test_unmapped

  // Reset in mid-run wipes flag and spare bits, line goes idle at once
  task automatic test_midreset;
    wr(16'h0000, 32'hFFFF_FFFF, 4'hF, 0, PLI_RESP_OKAY);
    irqchk(1'b0);
    @(negedge core_clk);
    arst_n = 1'b0;
    irqchk(PLI_IRQ_IDLE_N);
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    test_reset();
  endtask : test_midreset

  task automatic print_verdict;
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    test_reset();
    test_upper();
    test_tick();
    test_swset();
    test_race();
    test_unmapped();
    test_midreset();
    print_verdict();
  end

  // Watchdog, well beyond the hundred or so cycles needed
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : pli_irq_gen_tb_top
